// ### logic/phase_accumulator_oscillator.sv
`timescale 1ns/1ps

module phase_accumulator_oscillator #(
  parameter int ACC_W = 20
) (
  // system
  input  wire logic                clk,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [31:0]         prdata,
  // candidate source clocks, asynchronous to clk
  input  wire logic                highFreqInternalOsc,
  input  wire logic                logicCellOneOutput,
  input  wire logic                logicCellTwoOutput,
  input  wire logic                logicCellThreeOutput,
  input  wire logic                logicCellFourOutput,
  input  wire logic                midFreqInternalOsc500k,
  input  wire logic                midFreqInternalOsc32k,
  input  wire logic                referenceClockOutput,
  // synthesized clock and events
  output logic                     accumWrapPulse,
  output logic                     ncoOut,
  output logic                     ncoPin,
  output logic                     ncoPinOe,
  output logic                     irq
);

  initial
  begin
    if (ACC_W < 17 || ACC_W > 24)
      $error("ACC_W must fit three byte registers above sixteen bits");
  end

  ////////////////////////////////////////////////////////////////////////
  // source clock synchronisers

  logic [nco_pkg::SRC_PINS-1:0] srcPins, sync1_r, sync2_r, sync3_r;
  logic [nco_pkg::SRC_PINS-1:0] level_r, rise;

  // order of the pins is the select code
  assign srcPins = {referenceClockOutput, midFreqInternalOsc32k,
                    midFreqInternalOsc500k, logicCellFourOutput,
                    logicCellThreeOutput, logicCellTwoOutput,
                    logicCellOneOutput, highFreqInternalOsc};

  // three stages; a level counts once the last two agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end
    else
    begin
      sync1_r <= srcPins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // accepted level per pin, only moves when stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level_r <= '0;
    else
      level_r <= (level_r & (sync2_r ^ sync3_r)) | (sync3_r & ~(sync2_r ^ sync3_r));
  end

  // one-cycle rising edge per pin; level starts low like an idle pin, so no edge after reset
  assign rise = sync2_r & sync3_r & ~level_r;

  ////////////////////////////////////////////////////////////////////////
  // software visible registers and the hidden working increment

  logic [nco_pkg::CTRL_W-1:0] ctrl_r;
  logic [7:0]                 incLow_r;
  logic [7:0]                 incHigh_r;
  logic [ACC_W-17:0]          incUpp_r;
  logic [ACC_W-1:0]           incWork_r;
  logic [ACC_W-1:0]           acc_r;
  logic                       wrapFlag_r;
  logic                       mask_r;

  logic       enable, toggleMode, pinEnable, sysClkSel, srcEdge;
  logic [2:0] srcSel, pulseWidth;

  assign enable     = ctrl_r[nco_pkg::CTRL_EN_BIT];
  assign toggleMode = ctrl_r[nco_pkg::CTRL_TOGGLE_BIT];
  assign pinEnable  = ctrl_r[nco_pkg::CTRL_PIN_BIT];
  assign sysClkSel  = ctrl_r[nco_pkg::CTRL_SYS_BIT];
  assign srcSel     = ctrl_r[nco_pkg::CTRL_SEL_LSB +: 3];
  assign pulseWidth = ctrl_r[nco_pkg::CTRL_PW_LSB +: 3];

  // system clock source advances on every clk edge
  assign srcEdge = sysClkSel ? 1'b1 : rise[srcSel];

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setupPh, accessPh, wrEn, mapped;

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  // every access completes with no wait state
  assign pready   = 1'b1;
  assign wrEn     = accessPh & pwrite;

  always_comb
  begin
    if (paddr == nco_pkg::ADDR_CTRL)
      mapped = 1'b1;
    else if (paddr == nco_pkg::ADDR_INC_LOW || paddr == nco_pkg::ADDR_INC_HIGH)
      mapped = 1'b1;
    else if (paddr == nco_pkg::ADDR_INC_UPP || paddr == nco_pkg::ADDR_ACC_LOW)
      mapped = 1'b1;
    else if (paddr == nco_pkg::ADDR_ACC_HIGH || paddr == nco_pkg::ADDR_ACC_UPP)
      mapped = 1'b1;
    else if (paddr == nco_pkg::ADDR_STATUS || paddr == nco_pkg::ADDR_MASK)
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  assign pslverr = accessPh & ~mapped;

  logic wrCtrl, wrIncL, wrIncH, wrIncU, wrAccL, wrAccH, wrAccU, wrStat, wrMask;

  assign wrCtrl = wrEn && paddr == nco_pkg::ADDR_CTRL;
  assign wrIncL = wrEn && paddr == nco_pkg::ADDR_INC_LOW;
  assign wrIncH = wrEn && paddr == nco_pkg::ADDR_INC_HIGH;
  assign wrIncU = wrEn && paddr == nco_pkg::ADDR_INC_UPP;
  assign wrAccL = wrEn && paddr == nco_pkg::ADDR_ACC_LOW;
  assign wrAccH = wrEn && paddr == nco_pkg::ADDR_ACC_HIGH;
  assign wrAccU = wrEn && paddr == nco_pkg::ADDR_ACC_UPP;
  assign wrStat = wrEn && paddr == nco_pkg::ADDR_STATUS;
  assign wrMask = wrEn && paddr == nco_pkg::ADDR_MASK;

  ////////////////////////////////////////////////////////////////////////
  // control and mask

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= nco_pkg::CTRL_RESET;
      mask_r <= nco_pkg::MASK_RESET;
    end
    else
    begin
      if (wrCtrl)
        ctrl_r <= pwdata[nco_pkg::CTRL_W-1:0];
      if (wrMask)
        mask_r <= pwdata[nco_pkg::STAT_WRAP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // increment byte registers, software side of the double buffer

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      incLow_r  <= nco_pkg::INC_RESET[7:0];
      incHigh_r <= nco_pkg::INC_RESET[15:8];
      incUpp_r  <= nco_pkg::INC_RESET[ACC_W-1:16];
    end
    else
    begin
      if (wrIncL)
        incLow_r <= pwdata[7:0];
      if (wrIncH)
        incHigh_r <= pwdata[7:0];
      if (wrIncU)
        incUpp_r <= pwdata[ACC_W-17:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // working increment load
  // while running only a low byte write arms the load, so software that
  // writes upper and high first never has a half-updated step in use

  logic       loadPend_r, loadNow_r, loadRun;
  logic [1:0] loadCnt_r;

  // loads counted edges after the arming write; a new low write re-arms
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loadPend_r <= 1'b0;
      loadCnt_r  <= 2'h0;
    end
    else if (wrIncL && enable)
    begin
      loadPend_r <= 1'b1;
      loadCnt_r  <= 2'h0;
    end
    else if (!enable)
      loadPend_r <= 1'b0;
    else if (loadPend_r && srcEdge)
    begin
      loadCnt_r <= loadCnt_r + 2'h1;
      if (loadCnt_r + 2'h1 == nco_pkg::LOAD_EDGES)
        loadPend_r <= 1'b0;
    end
  end

  assign loadRun = loadPend_r && srcEdge && enable
                   && (loadCnt_r + 2'h1 == nco_pkg::LOAD_EDGES);

  // stopped: copy on the cycle after any increment write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      loadNow_r <= 1'b0;
    else
      loadNow_r <= (wrIncL | wrIncH | wrIncU) & ~enable;
  end

  // hidden working copy, never put on the read bus
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      incWork_r <= nco_pkg::INC_RESET[ACC_W-1:0];
    else if (loadRun || loadNow_r)
      incWork_r <= {incUpp_r, incHigh_r, incLow_r};
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator and adder

  logic [ACC_W:0] sum;
  logic           step;

  // full adder with the carry kept as the extra top bit
  assign sum  = {1'b0, acc_r} + {1'b0, incWork_r};
  assign step = enable & srcEdge;

  // software byte writes win over a step in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_r <= nco_pkg::ACC_RESET[ACC_W-1:0];
    else if (wrAccL)
      acc_r[7:0] <= pwdata[7:0];
    else if (wrAccH)
      acc_r[15:8] <= pwdata[7:0];
    else if (wrAccU)
      acc_r[ACC_W-1:16] <= pwdata[ACC_W-17:0];
    else if (step)
      acc_r <= sum[ACC_W-1:0];
  end

  // carry of a step is the raw output, one clk wide
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      accumWrapPulse <= 1'b0;
    else
      accumWrapPulse <= step & sum[ACC_W] & ~(wrAccL | wrAccH | wrAccU);
  end

  ////////////////////////////////////////////////////////////////////////
  // output shaping: toggle or stretched pulse

  logic [3:0] stretch_r;
  logic       toggle_r;

  // toggle halves the wrap rate but gives a near square wave
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      toggle_r <= 1'b0;
    else if (!enable)
      toggle_r <= 1'b0;
    else if (accumWrapPulse)
      toggle_r <= ~toggle_r;
  end

  // stretched pulse stays high for pulseWidth+1 source clock edges
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stretch_r <= 4'h0;
    else if (!enable)
      stretch_r <= 4'h0;
    else if (accumWrapPulse)
      stretch_r <= {1'b0, pulseWidth} + 4'h1;
    else if (srcEdge && stretch_r != 4'h0)
      stretch_r <= stretch_r - 4'h1;
  end

  // registered shaped output and pin drive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ncoOut   <= 1'b0;
      ncoPin   <= 1'b0;
      ncoPinOe <= 1'b0;
    end
    else
    begin
      ncoOut   <= toggleMode ? toggle_r : (stretch_r != 4'h0);
      ncoPin   <= pinEnable & (toggleMode ? toggle_r : (stretch_r != 4'h0));
      ncoPinOe <= pinEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrapFlag_r <= 1'b0;
    else if (accumWrapPulse)
      wrapFlag_r <= 1'b1;
    else if (wrStat && pwdata[nco_pkg::STAT_WRAP_BIT])
      wrapFlag_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= (wrapFlag_r | accumWrapPulse) & mask_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (setupPh && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      if (paddr == nco_pkg::ADDR_CTRL)
        prdata[nco_pkg::CTRL_W-1:0] <= ctrl_r;
      else if (paddr == nco_pkg::ADDR_INC_LOW)
        prdata[7:0] <= incLow_r;
      else if (paddr == nco_pkg::ADDR_INC_HIGH)
        prdata[7:0] <= incHigh_r;
      else if (paddr == nco_pkg::ADDR_INC_UPP)
        prdata[ACC_W-17:0] <= incUpp_r;
      else if (paddr == nco_pkg::ADDR_ACC_LOW)
        prdata[7:0] <= acc_r[7:0];
      else if (paddr == nco_pkg::ADDR_ACC_HIGH)
        prdata[7:0] <= acc_r[15:8];
      else if (paddr == nco_pkg::ADDR_ACC_UPP)
        prdata[ACC_W-17:0] <= acc_r[ACC_W-1:16];
      else if (paddr == nco_pkg::ADDR_STATUS)
      begin
        prdata[nco_pkg::STAT_WRAP_BIT] <= wrapFlag_r;
        prdata[nco_pkg::STAT_OUT_BIT]  <= ncoOut;
      end
      else if (paddr == nco_pkg::ADDR_MASK)
        prdata[nco_pkg::STAT_WRAP_BIT] <= mask_r;
    end
  end

endmodule : phase_accumulator_oscillator

// ### logic/nco_pkg.sv
package nco_pkg;

  // register byte addresses on the apb slave
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_INC_LOW  = 12'h004;
  localparam logic [11:0] ADDR_INC_HIGH = 12'h008;
  localparam logic [11:0] ADDR_INC_UPP  = 12'h00C;
  localparam logic [11:0] ADDR_ACC_LOW  = 12'h010;
  localparam logic [11:0] ADDR_ACC_HIGH = 12'h014;
  localparam logic [11:0] ADDR_ACC_UPP  = 12'h018;
  localparam logic [11:0] ADDR_STATUS   = 12'h01C;
  localparam logic [11:0] ADDR_MASK     = 12'h020;

  // control register field positions
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_TOGGLE_BIT = 1;
  localparam int CTRL_PIN_BIT    = 2;
  localparam int CTRL_SYS_BIT    = 3;
  localparam int CTRL_SEL_LSB    = 4;
  localparam int CTRL_PW_LSB     = 8;
  localparam int CTRL_W          = 11;

  // status and mask field positions
  localparam int STAT_WRAP_BIT = 0;
  localparam int STAT_OUT_BIT  = 1;

  // values after reset
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [23:0] INC_RESET  = 24'h00_0000;
  localparam logic [23:0] ACC_RESET  = 24'h00_0000;
  localparam logic        MASK_RESET = 1'h0;

  // source clock edges between a low increment write and the buffer load
  localparam logic [1:0] LOAD_EDGES = 2'h2;

  // eight selectable source pins; the system clock is picked by its own bit
  localparam int SRC_PINS = 8;

endpackage : nco_pkg

// ### verif/nco_properties.sv
`timescale 1ns/1ps

module nco_checker #(
  parameter int ACC_W = 20
) (
  // system and apb
  input wire logic        clk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // sources and shaped outputs
  input wire logic        highFreqInternalOsc, logicCellOneOutput, logicCellTwoOutput, logicCellThreeOutput,
  input wire logic        logicCellFourOutput, midFreqInternalOsc500k, midFreqInternalOsc32k, referenceClockOutput,
  input wire logic        accumWrapPulse, ncoOut, ncoPin, ncoPinOe, irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic acs;
  // access phase of an apb transfer
  assign acs = psel && penable;

  chk_ready_always: assert property (acs |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_err: assert property (acs && paddr > nco_pkg::ADDR_MASK |-> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acs && paddr <= nco_pkg::ADDR_MASK && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_refused_zero: assert property (acs && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  chk_upper_narrow: assert property (acs && !pwrite && (paddr == nco_pkg::ADDR_INC_UPP ||
    paddr == nco_pkg::ADDR_ACC_UPP) |-> prdata[31:4] == 28'h000_0000) else $error("upper byte too wide");
  chk_out_cause: assert property ($rose(ncoOut) |-> $past(accumWrapPulse, 2))
    else $error("output rose without a wrap");
  chk_pin_gate: assert property (ncoPin |-> ncoPinOe && ncoOut)
    else $error("pin driven without enable or output");
  chk_irq_cause: assert property ($rose(irq) |-> $past(accumWrapPulse) ||
    $past(acs && pwrite) || $past(acs && pwrite, 2)) else $error("irq rose without cause");
  chk_stop_quiet: assert property (acs && pwrite && paddr == nco_pkg::ADDR_CTRL && !pwdata[0]
    |-> ##2 !accumWrapPulse [*4]) else $error("wrap while disabled");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !accumWrapPulse && !ncoOut && !irq)
    else $error("output active right after reset");

  // main scenarios
  cover property (accumWrapPulse);
  cover property ($rose(irq));
  cover property (acs && pslverr);
endmodule : nco_checker

bind phase_accumulator_oscillator nco_checker #(.ACC_W(ACC_W)) u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .highFreqInternalOsc(highFreqInternalOsc), .logicCellOneOutput(logicCellOneOutput),
  .logicCellTwoOutput(logicCellTwoOutput), .logicCellThreeOutput(logicCellThreeOutput),
  .logicCellFourOutput(logicCellFourOutput), .midFreqInternalOsc500k(midFreqInternalOsc500k),
  .midFreqInternalOsc32k(midFreqInternalOsc32k), .referenceClockOutput(referenceClockOutput),
  .accumWrapPulse(accumWrapPulse), .ncoOut(ncoOut), .ncoPin(ncoPin), .ncoPinOe(ncoPinOe), .irq(irq));

// ### verif/nco_source_model.sv
`timescale 1ns/1ps

module nco_source_model (
  // system
  input  wire logic       clk,
  input  wire logic       rst_n,
  // which candidate runs, and whether any runs
  input  wire logic [2:0] pick,
  input  wire logic       run,
  // candidate source clocks
  output logic      [7:0] srcClk
);
  logic [2:0] cnt_r;

  // free counter; its top bit gives a clock of eight system periods
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_r + 3'h1;
  end

  // four clk per level clears the input filter; idle lines rest low
  assign srcClk = (run && cnt_r[2]) ? (8'h01 << pick) : 8'h00;
endmodule : nco_source_model

// ### verif/test_phase_accumulator_oscillator.sv
`timescale 1ns/1ps

module test_phase_accumulator_oscillator;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic [2:0]  pick = 3'h0;
  logic [7:0]  srcClk;
  logic        pready, pslverr, errSeen, wrap, ncoOut, ncoPin, ncoPinOe, irq;
  int          nFail = 0, nCompared = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  phase_accumulator_oscillator u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .highFreqInternalOsc(srcClk[0]), .logicCellOneOutput(srcClk[1]), .logicCellTwoOutput(srcClk[2]),
    .logicCellThreeOutput(srcClk[3]), .logicCellFourOutput(srcClk[4]), .midFreqInternalOsc500k(srcClk[5]),
    .midFreqInternalOsc32k(srcClk[6]), .referenceClockOutput(srcClk[7]), .accumWrapPulse(wrap),
    .ncoOut(ncoOut), .ncoPin(ncoPin), .ncoPinOe(ncoPinOe), .irq(irq));
  nco_source_model u_src (.clk(clk), .rst_n(rst_n), .pick(pick), .run(run), .srcClk(srcClk));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      nFail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 16);
    if (i >= 16)
    begin
      nFail++;
      print_verdict();
    end
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setInc(input logic [19:0] v);
    apb(1'b1, nco_pkg::ADDR_INC_UPP, {28'h000_0000, v[19:16]});
    apb(1'b1, nco_pkg::ADDR_INC_HIGH, {24'h00_0000, v[15:8]});
    apb(1'b1, nco_pkg::ADDR_INC_LOW, {24'h00_0000, v[7:0]});
  endtask : setInc

  // counts wrap pulses and high output cycles over a fixed window
  task automatic countWin(input int n, output int w, output int h);
    w = 0;
    h = 0;
    repeat (n) @(posedge clk) begin w += (wrap === 1'b1); h += (ncoOut === 1'b1); end
  endtask : countWin

  ////////////////////////////////////////////////////////////////////////////////
  task automatic testRegs();
    int w, h;
    apb(1'b0, nco_pkg::ADDR_CTRL, 32'h0000_0000); check(rd, 32'h0000_0000);
    apb(1'b0, 12'h040, 32'h0000_0000); check({errSeen, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h040, 32'h0000_00FF); check(errSeen, 1'b1);
    setInc(20'hF_3412);
    apb(1'b0, nco_pkg::ADDR_INC_UPP, 32'h0000_0000); check(rd, 32'h0000_000F);
    apb(1'b0, nco_pkg::ADDR_INC_HIGH, 32'h0000_0000); check(rd, 32'h0000_0034);
    apb(1'b0, nco_pkg::ADDR_INC_LOW, 32'h0000_0000); check(rd, 32'h0000_0012);
    apb(1'b1, nco_pkg::ADDR_ACC_LOW, 32'h0000_0045);
    apb(1'b1, nco_pkg::ADDR_ACC_UPP, 32'h0000_00FA);
    countWin(20, w, h); check(w, 0);
    apb(1'b0, nco_pkg::ADDR_ACC_LOW, 32'h0000_0000); check(rd, 32'h0000_0045);
    apb(1'b0, nco_pkg::ADDR_ACC_UPP, 32'h0000_0000); check(rd, 32'h0000_000A);
  endtask : testRegs

  // system clock source: wrap and output rates over exact windows
  task automatic testRate();
    logic [19:0] inc [4] = '{20'h8_0000, 20'h4_0000, 20'h4_0000, 20'h6_0000};
    logic [31:0] ctl [4] = '{32'h0000_000F, 32'h0000_000F, 32'h0000_000D, 32'h0000_000D};
    int len [4] = '{40, 64, 64, 64};
    int ew [4] = '{20, 16, 16, 24};
    int eh [4] = '{20, 32, 16, 24};
    int w, h;
    apb(1'b1, nco_pkg::ADDR_MASK, 32'h0000_0001);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, nco_pkg::ADDR_CTRL, 32'h0000_0000);
      setInc(inc[k]);
      apb(1'b1, nco_pkg::ADDR_CTRL, ctl[k]);
      repeat (8) @(posedge clk);
      countWin(len[k], w, h);
      check(w, ew[k]);
      check(h, eh[k]);
      check({ncoPinOe, ncoPin}, {1'b1, ncoOut});
      check(irq, 1'b1);
    end
  endtask : testRate

  // sticky wrap flag, mask and write-one clear
  task automatic testIrq();
    apb(1'b1, nco_pkg::ADDR_CTRL, 32'h0000_0000);
    // a late stretched pulse can still show in the status output bit for two cycles
    repeat (3) @(posedge clk);
    apb(1'b0, nco_pkg::ADDR_STATUS, 32'h0000_0000); check(rd, 32'h0000_0001);
    apb(1'b1, nco_pkg::ADDR_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk); check(irq, 1'b0);
    apb(1'b1, nco_pkg::ADDR_MASK, 32'h0000_0001);
    repeat (3) @(posedge clk); check(irq, 1'b1);
    apb(1'b1, nco_pkg::ADDR_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clk); check(irq, 1'b0);
    apb(1'b0, nco_pkg::ADDR_STATUS, 32'h0000_0000); check(rd, 32'h0000_0000);
  endtask : testIrq

  // every source select code, plus an idle wrong line that must not step
  task automatic testSources();
    int w, h;
    setInc(20'h8_0000);
    run <= 1'b1;
    for (int s = 0; s < 9; s++)
    begin
      pick <= (s == 8) ? 3'h1 : 3'(s);
      apb(1'b1, nco_pkg::ADDR_CTRL, {25'h000_0000, (s == 8) ? 3'h0 : 3'(s), 4'h1});
      repeat (16) @(posedge clk);
      countWin(80, w, h);
      check(w, (s == 8) ? 0 : 5);
    end
    run <= 1'b0;
  endtask : testSources

  // running step change: upper and high wait for the low write, which loads on the second edge
  task automatic testLoad();
    int w, h, first;
    apb(1'b1, nco_pkg::ADDR_CTRL, 32'h0000_0000);
    setInc(20'h0_0000);
    apb(1'b1, nco_pkg::ADDR_ACC_UPP, 32'h0000_0008);
    apb(1'b1, nco_pkg::ADDR_CTRL, 32'h0000_0309);
    apb(1'b1, nco_pkg::ADDR_INC_UPP, 32'h0000_0008);
    apb(1'b1, nco_pkg::ADDR_INC_HIGH, 32'h0000_0000);
    countWin(16, w, h); check(w, 0);
    apb(1'b1, nco_pkg::ADDR_INC_LOW, 32'h0000_0000);
    // load at the second edge, first carrying step one edge later, seen one sample after that
    first = 0;
    for (int j = 1; j <= 8; j++)
    begin
      @(posedge clk);
      if (first == 0 && wrap === 1'b1)
        first = j;
    end
    check(first, 4);
    // stretch of four source edges per wrap, pin left off
    apb(1'b1, nco_pkg::ADDR_CTRL, 32'h0000_0000);
    setInc(20'h2_0000);
    apb(1'b1, nco_pkg::ADDR_CTRL, 32'h0000_0309);
    repeat (8) @(posedge clk);
    countWin(64, w, h);
    check(w, 8);
    check(h, 32);
    check({ncoPinOe, ncoPin}, 2'h0);
  endtask : testLoad

  ////////////////////////////////////////////////////////////////////////////////
  // reset held four cycles, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    check({wrap, ncoOut, irq}, 3'h0);
    testRegs();
    testRate();
    testIrq();
    testSources();
    testLoad();
    print_verdict();
  end
endmodule : test_phase_accumulator_oscillator
